// file: include/hsmc_pkg.sv
// constants, mode codes, state codes and lookup tables of the hall sensor mode control
// assumes a single 50 MHz clock domain; the link pins arrive unsynchronised
// What this block does
// - after reset the device answers only its default 7-bit bus address
// - host may write a new bus address; device then answers that one
// - address byte is address shifted left with direction bit, 0 write, 1 read
// - one range bit for x and y, another for z; 1 doubles range
// - 3-bit averaging code 000 to 101 sets rate; other codes undefined
// - code 000 gives 20.0, 13.3, 10.0 kSPS for one, two, three axes
// - operating mode field selects standby, sleep, wake-and-sleep or continuous
// - after power-up the device enters standby, ready for commands
// - in standby a bus trigger or interrupt pin starts one conversion
// - standby keeps last results until a newer conversion overwrites them
// - sleep keeps configuration and discards result data
// - bus access or interrupt pin wakes sleep into standby
// - wake-and-sleep sleeps, wakes after selected interval, measures, repeats
// - wake intervals 1, 5, 10, 15, 20, 30, 50, 100, 500, 1000, 2000, 5000, 20000 ms
// - wake-and-sleep conversion meeting threshold stores results, goes standby
// - threshold not met: stay in wake-and-sleep and keep measuring
// - bus access or interrupt pin ends wake-and-sleep into standby at any time
// - continuous mode converts without pause, results stay readable
// - registers usable only in standby and continuous; configuration kept always
// - standby reached about 270 us after power-up
// - standby reached about 50 us after waking from sleep or wake-and-sleep
// - continuous mode entered about 70 us after command from standby
// - address seen in sleep wakes without acknowledge; host waits startup time
package hsmc_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_PWRUP_NS = 270000;
  localparam int unsigned T_WAKE_NS = 50000;
  localparam int unsigned T_MEAS_NS = 70000;
  localparam int unsigned T_MS_NS = 1000000;
  localparam int unsigned PWRUP_CYC_DEF = (T_PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MEAS_CYC = (T_MEAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_CYC_DEF = T_MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CLK_HZ_DEF = 1000000000 / CLK_PERIOD_NS;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_THR = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RES = 8'h10;
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_XY_RANGE = 7;
  localparam int CFG_Z_RANGE = 8;
  localparam int CFG_AVG_LSB = 9;
  localparam int CFG_MODE_LSB = 12;
  localparam int CFG_IVL_LSB = 14;
  localparam int CFG_AXIS_LSB = 18;
  localparam int STAT_BUSY = 8;
  localparam int STAT_VALID = 9;
  localparam int STAT_RD = 10;
  localparam int STAT_CNT_LSB = 16;
  localparam logic [6:0] DEF_BUS_ADDR = 7'h35;
  localparam logic [2:0] AVG_MAX = 3'h5;
  localparam logic [3:0] IVL_MAX = 4'hc;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // ****************************************
  // modes and states
  // ****************************************
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] MODE_WS = 2'h3;
  typedef enum logic [7:0] {
    ST_PWRUP = 8'h01,
    ST_STANDBY = 8'h02,
    ST_SLEEP = 8'h04,
    ST_WAKE = 8'h08,
    ST_WS_WAIT = 8'h10,
    ST_WS_CONV = 8'h20,
    ST_CONT_GO = 8'h40,
    ST_CONT = 8'h80
  } hsmc_state_type;
  // ****************************************
  // rate and interval tables
  // ****************************************
  // sample rate in units of 0.1 kSPS, axes is 1..3
  function automatic int unsigned hsmc_rate_x10(int unsigned code, int unsigned axes);
    int unsigned t [6][3];
    t = '{'{200, 133, 100}, '{133, 80, 57}, '{80, 44, 31},
          '{44, 24, 16}, '{24, 12, 8}, '{12, 6, 4}};
    return t[code][axes - 1];
  endfunction : hsmc_rate_x10
  function automatic logic [14:0] hsmc_ivl_ms(logic [3:0] sel);
    logic [14:0] ms;
    ms = 15'h0001;
    unique case (sel)
      4'h0: ms = 15'd1;
      4'h1: ms = 15'd5;
      4'h2: ms = 15'd10;
      4'h3: ms = 15'd15;
      4'h4: ms = 15'd20;
      4'h5: ms = 15'd30;
      4'h6: ms = 15'd50;
      4'h7: ms = 15'd100;
      4'h8: ms = 15'd500;
      4'h9: ms = 15'd1000;
      4'ha: ms = 15'd2000;
      4'hb: ms = 15'd5000;
      4'hc: ms = 15'd20000;
      default: ms = 15'd1;
    endcase
    return ms;
  endfunction : hsmc_ivl_ms
endpackage : hsmc_pkg

// file: logic/hsmc_link.sv
// two-wire link watcher: finds start, shifts the address byte, matches it
// assumes scl and sda are raw pins, sampled here by the block clock
`timescale 1ns/1ps
`default_nettype none
module hsmc_link
  import hsmc_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // pins
  input wire logic i_scl,
  input wire logic i_sda,
  // match
  input wire logic [6:0] i_addr,
  output logic o_hit,
  output logic o_hit_rd
);
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_p_q;
  logic sda_p_q;
  logic [7:0] shift_q;
  logic [3:0] bits_q;
  logic armed_q;
  logic start_c;
  logic rise_c;

  // ****************************************
  // synchronisers
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (i_ce) begin
      scl_s_q <= {scl_s_q[0], i_scl};
      sda_s_q <= {sda_s_q[0], i_sda};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  assign start_c = scl_s_q[1] && scl_p_q && sda_p_q && !sda_s_q[1];
  assign rise_c = scl_s_q[1] && !scl_p_q;

  // ****************************************
  // address byte
  // ****************************************
  // only the first byte after a start is compared; data bytes are not decoded here
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      shift_q <= 8'h00;
      bits_q <= 4'h0;
      armed_q <= 1'b0;
      o_hit <= 1'b0;
      o_hit_rd <= 1'b0;
    end else if (i_ce) begin
      o_hit <= 1'b0;
      if (start_c) begin
        bits_q <= 4'h0;
        armed_q <= 1'b1;
      end else if (rise_c && armed_q) begin
        shift_q <= {shift_q[6:0], sda_s_q[1]};
        bits_q <= bits_q + 4'h1;
        if (bits_q == 4'h7) begin
          armed_q <= 1'b0;
          o_hit <= (shift_q[6:0] == i_addr);
          o_hit_rd <= sda_s_q[1];
        end
      end
    end
  end
endmodule : hsmc_link
`default_nettype wire

// file: logic/hsmc_top.sv
// mode control of a three-axis hall sensor with an axi4-lite register port
// assumes axi master on i_mclk; scl, sda and int_n pins are asynchronous
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module hsmc_top
  import hsmc_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF,
  parameter int unsigned PWRUP_CYC = PWRUP_CYC_DEF,
  parameter int unsigned MS_CYC = MS_CYC_DEF
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // axi4-lite write
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_int_n,
  // sensor front end
  input wire logic [15:0] i_meas_data,
  output logic o_conv_start,
  output logic o_range_xy,
  output logic o_range_z,
  output logic o_addr_ack
);
  logic [31:0] conv_tab [6][3];
  hsmc_state_type state_q;
  hsmc_state_type state_d;
  logic [6:0] bus_addr_q;
  logic xy_range_q;
  logic z_range_q;
  logic [2:0] avg_q;
  logic [1:0] mode_q;
  logic [3:0] ivl_q;
  logic [2:0] axis_q;
  logic [15:0] thr_q;
  logic [15:0] res_q;
  logic res_valid_q;
  logic [15:0] conv_cnt_q;
  logic busy_q;
  logic [31:0] conv_tmr_q;
  logic [31:0] tmr_q;
  logic [14:0] ms_left_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] int_s_q;
  logic int_p_q;
  logic int_fall_c;
  logic link_hit;
  logic link_rd;
  logic last_rd_q;
  logic regs_open_c;
  logic wr_do_c;
  logic rd_do_c;
  logic bus_wake_c;
  logic wake_c;
  logic trig_c;
  logic start_c;
  logic done_c;
  logic met_c;
  logic mode_req_c;
  logic [1:0] mode_new_c;
  logic [31:0] wr_word_c;

  // ****************************************
  // conversion period table and checks
  // ****************************************
  for (genvar c = 0; c < 6; c++) begin : g_rate
    for (genvar a = 0; a < 3; a++) begin : g_axes
      assign conv_tab[c][a] = 32'(CLK_HZ / (hsmc_rate_x10(c, a + 1) * 100));
    end
  end
  if (CLK_HZ < 400000 || MS_CYC < 1 || PWRUP_CYC < 1) begin : g_chk
    $error("hsmc_top: clock rate or counts too small");
  end

  function automatic logic [1:0] axes_idx(logic [2:0] en);
    logic [1:0] n;
    n = 2'(en[0]) + 2'(en[1]) + 2'(en[2]);
    return (n == 2'h0) ? 2'h0 : n - 2'h1;
  endfunction : axes_idx

  // ****************************************
  // link and interrupt pin
  // ****************************************
  hsmc_link u_link (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_addr(bus_addr_q),
    .o_hit(link_hit),
    .o_hit_rd(link_rd)
  );

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      int_s_q <= 2'h3;
      int_p_q <= 1'b1;
    end else if (i_ce) begin
      int_s_q <= {int_s_q[0], i_int_n};
      int_p_q <= int_s_q[1];
    end
  end
  assign int_fall_c = int_p_q && !int_s_q[1];

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign regs_open_c = (state_q == ST_STANDBY) || (state_q == ST_CONT);
  assign o_awready = !aw_full_q && i_ce;
  assign o_wready = !w_full_q && i_ce;
  assign o_arready = !o_rvalid && i_ce;
  assign wr_do_c = aw_full_q && w_full_q && !o_bvalid;
  assign rd_do_c = i_arvalid && o_arready;
  // a bus access while asleep is not served but still rouses the device
  assign bus_wake_c = (wr_do_c || rd_do_c) && !regs_open_c;
  assign wake_c = bus_wake_c || link_hit || int_fall_c;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= AXI_OKAY;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (wr_do_c) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (regs_open_c && (aw_addr_q[7:2] <= REG_RES[7:2]) && aw_addr_q[1:0] == 2'h0)
                   ? AXI_OKAY : AXI_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= AXI_OKAY;
    end else if (i_ce) begin
      if (rd_do_c) begin
        o_rvalid <= 1'b1;
        o_rresp <= regs_open_c ? AXI_OKAY : AXI_SLVERR;
        o_rdata <= 32'h0000_0000;
        if (regs_open_c) begin
          unique case (i_araddr)
            REG_CFG: o_rdata <= {11'h000, axis_q, ivl_q, mode_q, avg_q, z_range_q, xy_range_q, bus_addr_q};
            REG_CMD: o_rdata <= 32'h0000_0000;
            REG_THR: o_rdata <= {16'h0000, thr_q};
            REG_STAT: o_rdata <= {conv_cnt_q, 5'h00, last_rd_q, res_valid_q, busy_q, state_q};
            REG_RES: o_rdata <= {16'h0000, res_q};
            default: o_rresp <= AXI_SLVERR;
          endcase
        end
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_word_c[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] : 8'h00;
    end
  end
  assign mode_req_c = wr_do_c && regs_open_c && aw_addr_q == REG_CFG && w_strb_q[1];
  assign mode_new_c = wr_word_c[CFG_MODE_LSB +: 2];

  // configuration survives every mode; only reset restores it, except mode_q, which entering standby sets back to MODE_STANDBY
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      bus_addr_q <= DEF_BUS_ADDR;
      xy_range_q <= 1'b0;
      z_range_q <= 1'b0;
      avg_q <= 3'h0;
      mode_q <= MODE_STANDBY;
      ivl_q <= 4'h0;
      axis_q <= 3'h7;
      thr_q <= 16'h7fff;
    end else if (i_ce) begin
      if (wr_do_c && regs_open_c && aw_addr_q == REG_CFG) begin
        if (w_strb_q[0]) begin
          bus_addr_q <= w_data_q[CFG_ADDR_LSB +: 7];
          xy_range_q <= w_data_q[CFG_XY_RANGE];
        end
        if (w_strb_q[1]) begin
          z_range_q <= w_data_q[CFG_Z_RANGE];
          if (w_data_q[CFG_AVG_LSB +: 3] <= AVG_MAX) begin
            avg_q <= w_data_q[CFG_AVG_LSB +: 3];
          end
        end
        if (w_strb_q[1] && w_strb_q[2] && wr_word_c[CFG_IVL_LSB +: 4] <= IVL_MAX) begin
          ivl_q <= wr_word_c[CFG_IVL_LSB +: 4];
        end
        if (w_strb_q[2]) begin
          axis_q <= w_data_q[CFG_AXIS_LSB +: 3];
        end
      end
      if (wr_do_c && regs_open_c && aw_addr_q == REG_THR) begin
        thr_q <= wr_word_c[15:0];
      end
      if (state_d == ST_STANDBY && state_q != ST_STANDBY) begin
        mode_q <= MODE_STANDBY;
      end else if (mode_req_c) begin
        mode_q <= mode_new_c;
      end
    end
  end
  assign o_range_xy = xy_range_q;
  assign o_range_z = z_range_q;

  // ****************************************
  // conversion engine
  // ****************************************
  assign trig_c = (wr_do_c && regs_open_c && aw_addr_q == REG_CMD && w_strb_q[0] && w_data_q[0])
                  || int_fall_c;
  assign start_c = !busy_q && (((state_q == ST_STANDBY) && trig_c && !mode_req_c)
                   || (state_q == ST_CONT)
                   || (state_q == ST_WS_WAIT && ms_left_q == 15'h0001 && tmr_q == 32'h1 && !wake_c));
  assign done_c = busy_q && conv_tmr_q == 32'h1;
  assign met_c = $signed(i_meas_data) >= $signed(thr_q) || $signed(i_meas_data) <= -$signed(thr_q);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      busy_q <= 1'b0;
      conv_tmr_q <= 32'h0;
      o_conv_start <= 1'b0;
    end else if (i_ce) begin
      o_conv_start <= start_c;
      if (start_c) begin
        busy_q <= 1'b1;
        conv_tmr_q <= conv_tab[avg_q][axes_idx(axis_q)];
      end else if (done_c || state_q == ST_SLEEP || state_q == ST_WAKE) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        conv_tmr_q <= conv_tmr_q - 32'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      res_q <= 16'h0000;
      res_valid_q <= 1'b0;
      conv_cnt_q <= 16'h0000;
    end else if (i_ce) begin
      if (state_q == ST_SLEEP) begin
        res_q <= 16'h0000;
        res_valid_q <= 1'b0;
      end else if (done_c) begin
        res_q <= i_meas_data;
        res_valid_q <= 1'b1;
        conv_cnt_q <= conv_cnt_q + 16'h1;
      end
    end
  end

  // ****************************************
  // operating mode state machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_PWRUP: if (tmr_q == 32'h1) state_d = ST_STANDBY;
      ST_STANDBY: begin
        if (mode_req_c && mode_new_c == MODE_SLEEP) state_d = ST_SLEEP;
        else if (mode_req_c && mode_new_c == MODE_CONT) state_d = ST_CONT_GO;
        else if (mode_req_c && mode_new_c == MODE_WS) state_d = ST_WS_WAIT;
      end
      ST_SLEEP: if (wake_c) state_d = ST_WAKE;
      ST_WAKE: if (tmr_q == 32'h1) state_d = ST_STANDBY;
      ST_WS_WAIT: begin
        if (wake_c) state_d = ST_WAKE;
        else if (start_c) state_d = ST_WS_CONV;
      end
      ST_WS_CONV: begin
        if (wake_c) state_d = ST_WAKE;
        else if (done_c && met_c) state_d = ST_STANDBY;
        else if (done_c) state_d = ST_WS_WAIT;
      end
      ST_CONT_GO: if (tmr_q == 32'h1) state_d = ST_CONT;
      ST_CONT: begin
        if (mode_req_c && mode_new_c == MODE_STANDBY) state_d = ST_STANDBY;
        else if (mode_req_c && mode_new_c == MODE_SLEEP) state_d = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q <= ST_PWRUP;
      tmr_q <= PWRUP_CYC;
      ms_left_q <= 15'h0001;
      o_addr_ack <= 1'b0;
      last_rd_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      // an address seen while asleep wakes only; no acknowledge goes out
      o_addr_ack <= link_hit && regs_open_c;
      if (link_hit) begin
        last_rd_q <= link_rd;
      end
      if (state_d != state_q) begin
        unique case (state_d)
          ST_WAKE: tmr_q <= WAKE_CYC;
          ST_CONT_GO: tmr_q <= MEAS_CYC;
          default: tmr_q <= MS_CYC;
        endcase
        ms_left_q <= hsmc_ivl_ms(ivl_q);
      end else if (state_q == ST_WS_WAIT && tmr_q == 32'h1) begin
        tmr_q <= MS_CYC;
        ms_left_q <= ms_left_q - 15'h1;
      end else if (tmr_q != 32'h1) begin
        tmr_q <= tmr_q - 32'h1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_pwrup_to_standby: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state_q == ST_PWRUP && tmr_q == 32'h1 && i_ce) |=> state_q == ST_STANDBY)
    else $error("power-up did not reach standby");
  a_wake_leaves_sleep: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state_q == ST_SLEEP && wake_c && i_ce) |=> state_q == ST_WAKE && tmr_q == WAKE_CYC)
    else $error("sleep did not wake");
  a_ws_exit_wake: assert property (@(posedge i_mclk) disable iff (i_srst)
    ((state_q == ST_WS_WAIT || state_q == ST_WS_CONV) && wake_c && i_ce) |=> state_q == ST_WAKE)
    else $error("wake-and-sleep ignored a wake request");
  a_ws_met_exit: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state_q == ST_WS_CONV && done_c && met_c && !wake_c && i_ce)
    |=> state_q == ST_STANDBY && res_q == $past(i_meas_data) && mode_q == MODE_STANDBY)
    else $error("threshold exit failed");
  a_ws_not_met: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state_q == ST_WS_CONV && done_c && !met_c && !wake_c && i_ce) |=> state_q == ST_WS_WAIT)
    else $error("wake-and-sleep left without threshold");
  a_sleep_drops_res: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state_q == ST_SLEEP && i_ce) |=> !res_valid_q && res_q == 16'h0000)
    else $error("result survived sleep");
  a_standby_trigger: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state_q == ST_STANDBY && !busy_q && int_fall_c && !mode_req_c && i_ce) |=> o_conv_start && busy_q)
    else $error("trigger did not start conversion");
  a_closed_regs_err: assert property (@(posedge i_mclk) disable iff (i_srst)
    (rd_do_c && !regs_open_c && i_ce) |=> o_rvalid && o_rresp == AXI_SLVERR)
    else $error("register read served while asleep");
  a_no_ack_asleep: assert property (@(posedge i_mclk) disable iff (i_srst)
    (link_hit && state_q == ST_SLEEP && i_ce) |=> !o_addr_ack ##1 state_q == ST_WAKE)
    else $error("acknowledged while asleep");
  a_cont_busy: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state_q == ST_CONT && !busy_q && i_ce) |=> busy_q || state_q != ST_CONT)
    else $error("continuous mode paused");
endmodule : hsmc_top
`default_nettype wire

// file: dv/hsmc_host_model.sv
// two-wire primary model: start, one address byte msb first, stop
// assumes lines idle high through pull-ups between frames
`timescale 1ns/1ps
`default_nettype none
module hsmc_host_model (
  // pins
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // 160 ns link period; scl stands still outside frames
  task automatic send(input logic [7:0] b);
    // step off the block clock edges so pin changes never race its sampling
    #5;
    o_sda = 1'b0;
    #80;
    for (int i = 7; i >= 0; i--) begin
      o_scl = 1'b0;
      #40 o_sda = b[i];
      #40 o_scl = 1'b1;
      #80;
    end
    o_scl = 1'b0;
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b1;
    #400;
  endtask : send
endmodule : hsmc_host_model
`default_nettype wire

// file: dv/test_hsmc_top.sv
// self-checking bench of hsmc_top: axi registers, link address, modes
// assumes hsmc_host_model on the pins; short power-up and ms counts
`timescale 1ns/1ps
`default_nettype none
module test_hsmc_top;
  import hsmc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] s;} hsmc_row_type;
  hsmc_row_type rows [5] = '{'{REG_CFG, 32'h001c0bb5, 32'h001c0bb5, AXI_OKAY},
    '{REG_CFG, 32'h001c0db5, 32'h001c0bb5, AXI_OKAY}, '{REG_THR, 32'h100, 32'h100, AXI_OKAY},
    '{8'h14, 32'h1, 32'h0, AXI_SLVERR}, '{8'h02, 32'h1, 32'h0, AXI_SLVERR}};
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, ce = 1'b1;
  logic [3:0] strb = 4'hf;
  logic int_n = 1'b1, awr, wrdy, bv, arr, rv, cs, rxy, rz, ack, scl, sda;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata, v;
  logic [15:0] meas = 16'h1234;
  logic [1:0] bresp, rresp, r;
  int err_count = 0, samples_checked = 0, cyc = 0, n_ack = 0, n_cs = 0;
  hsmc_top #(.CLK_HZ(1000000), .PWRUP_CYC(20), .MS_CYC(20)) uut (.i_mclk(clk), .i_srst(rst),
    .i_ce(ce), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(strb),
    .i_wvalid(wv), .o_wready(wrdy), .o_bresp(bresp), .o_bvalid(bv), .i_bready(br), .i_araddr(ara),
    .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
    .i_rready(rr), .i_scl(scl), .i_sda(sda), .i_int_n(int_n), .i_meas_data(meas),
    .o_conv_start(cs), .o_range_xy(rxy), .o_range_z(rz), .o_addr_ack(ack));
  hsmc_host_model host (.o_scl(scl), .o_sda(sda));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_ack <= n_ack + int'(ack === 1'b1);
    n_cs <= n_cs + int'(cs === 1'b1);
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic axw(logic [7:0] a, logic [31:0] d, output logic [1:0] s);
    logic ta, tw, t;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      t = bv;
      s = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (t !== 1'b1);
    br <= 1'b0;
  endtask : axw
  task automatic rchk(string n, logic [7:0] a, logic [31:0] m, logic [31:0] e, logic [1:0] es);
    logic ta, t;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv && arr;
      t = rv;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (t !== 1'b1);
    rr <= 1'b0;
    cmp({n, " rresp"}, 32'(es), 32'(r));
    cmp(n, e, v & m);
  endtask : rchk
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk("early stat", REG_STAT, 32'h0, 32'h0, AXI_SLVERR);
    repeat (25) @(posedge clk);
    rchk("stat", REG_STAT, 32'hff, 32'h02, AXI_OKAY);
    rchk("cfg", REG_CFG, 32'h1fffff, 32'h1c0035, AXI_OKAY);
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].d, r);
      cmp("bresp", 32'(rows[i].s), 32'(r));
      rchk("row", rows[i].a, 32'hffffffff, rows[i].e, rows[i].s);
    end
    cmp("ranges", 32'h3, {30'h0, rxy, rz});
    strb <= 4'h1;
    axw(REG_CFG, 32'h00001f35, r);
    strb <= 4'hf;
    rchk("lane cfg", REG_CFG, 32'h1fffff, 32'h1c0b35, AXI_OKAY);
    cmp("ranges", 32'h1, {30'h0, rxy, rz});
    axw(REG_CFG, 32'h001c0035, r);
    host.send(8'h6a);
    host.send(8'h44);
    cmp("ack count", 32'd1, 32'(n_ack));
    axw(REG_CFG, 32'h001c0022, r);
    host.send(8'h45);
    cmp("ack count", 32'd2, 32'(n_ack));
    rchk("rw bit", REG_STAT, 32'h400, 32'h400, AXI_OKAY);
    axw(REG_CMD, 32'h1, r);
    repeat (200) @(posedge clk);
    rchk("result", REG_RES, 32'hffff, 32'h1234, AXI_OKAY);
    meas <= 16'h0321;
    int_n <= 1'b0;
    repeat (200) @(posedge clk);
    int_n <= 1'b1;
    rchk("result", REG_RES, 32'hffff, 32'h0321, AXI_OKAY);
    cmp("starts", 32'd2, 32'(n_cs));
    ce <= 1'b0;
    int_n <= 1'b0;
    repeat (20) @(posedge clk);
    cmp("frozen starts", 32'd2, 32'(n_cs));
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    cmp("thawed starts", 32'd3, 32'(n_cs));
    int_n <= 1'b1;
    repeat (200) @(posedge clk);
    axw(REG_CFG, 32'h001c1022, r);
    rchk("sleep stat", REG_STAT, 32'h0, 32'h0, AXI_SLVERR);
    repeat (2600) @(posedge clk);
    rchk("woken stat", REG_STAT, 32'h2ff, 32'h002, AXI_OKAY);
    rchk("kept cfg", REG_CFG, 32'h1fffff, 32'h1c0022, AXI_OKAY);
    axw(REG_CFG, 32'h001c1022, r);
    host.send(8'h44);
    cmp("ack count", 32'd2, 32'(n_ack));
    repeat (2600) @(posedge clk);
    rchk("link wake", REG_STAT, 32'hff, 32'h02, AXI_OKAY);
    axw(REG_CFG, 32'h001c3022, r);
    repeat (400) @(posedge clk);
    rchk("ws exit", REG_STAT, 32'h2ff, 32'h202, AXI_OKAY);
    meas <= 16'h0010;
    axw(REG_CFG, 32'h001c3022, r);
    repeat (400) @(posedge clk);
    cmp("ws repeats", 32'd1, 32'(n_cs >= 7));
    int_n <= 1'b0;
    repeat (2600) @(posedge clk);
    int_n <= 1'b1;
    rchk("ws wake", REG_STAT, 32'hff, 32'h02, AXI_OKAY);
    meas <= 16'h0777;
    axw(REG_CFG, 32'h001c2022, r);
    repeat (3700) @(posedge clk);
    rchk("cont stat", REG_STAT, 32'hff, 32'h80, AXI_OKAY);
    rchk("cont res", REG_RES, 32'hffff, 32'h0777, AXI_OKAY);
    complete_run();
  end
endmodule : test_hsmc_top
`default_nettype wire
